//--- rot_pkg.sv
// Purpose: Shared types and constants for the bit rotate unit.
// Assumes: One clock domain; requests arrive synchronous to clk.
// Notes: Operation codes follow a Gray sequence.
package rot_pkg;

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam int HALF_W = 16;
   localparam int COUNT_W = 16;
   localparam int N16_W = 4;
   localparam int N32_W = 5;
   localparam logic CARRY_RESET = 1'h0;
   localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

   // Operation select, Gray coded along the listed order.
   typedef enum logic [1:0] {
      rotate_left_16 = 2'h0,
      rotate_right_carry_16 = 2'h1,
      rotate_left_carry_16 = 2'h3,
      rotate_right_32 = 2'h2
   } rot_op_t;

   // Request from the instruction sequencer.
   typedef struct packed {
      rot_op_t op;
      logic [COUNT_W-1:0] count;
      logic [WORD_W-1:0] operand;
   } rot_req_t;

   // Registered answer to the sequencer.
   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic carry_flag;
      logic done;
   } rot_res_t;

endpackage : rot_pkg

//--- bit_rotate_unit.sv
// Purpose: Single-cycle rotate datapath with a one-bit carry flag.
// Assumes: The sequencer raises enable for one cycle per instruction.
// Notes: 16-bit operations pass operand bits 31..16 through unchanged.
`timescale 1ns/1ps
module bit_rotate_unit
   import rot_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic enable,
   input wire rot_req_t req,
   output rot_res_t res
);

   // ----------------------------------------------------------------
   // Count decoding
   // ----------------------------------------------------------------
   rot_res_t res_reg;
   rot_res_t res_next;
   wire logic [N16_W-1:0] n16;
   wire logic [N32_W-1:0] n32;
   wire logic [7:0] count_byte;
   wire logic zero16;
   wire logic zero32;
   wire logic [HALF_W-1:0] d16;
   wire logic [WORD_W-1:0] d32;
   wire logic carry_old;

   // 16-bit counts wrap at 16, so only the low nibble matters.
   // modulo sixteen count
   assign n16 = req.count[N16_W-1:0];
   assign count_byte = req.count[7:0];
   assign n32 = count_byte[N32_W-1:0];
   assign zero16 = (n16 == 4'h0);
   assign zero32 = (n32 == 5'h00);
   assign d16 = req.operand[HALF_W-1:0];
   assign d32 = req.operand;
   assign carry_old = res_reg.carry_flag;

   // ----------------------------------------------------------------
   // Rotators
   // ----------------------------------------------------------------
   // Each rotate shifts a doubled copy of the word, so one barrel
   // shifter replaces a mux per count value.
   wire logic [2*HALF_W-1:0] rol_pair;
   wire logic [HALF_W-1:0] rol_word;
   wire logic [HALF_W:0] rc_ext;
   wire logic [2*HALF_W+1:0] rcr_pair;
   wire logic [2*HALF_W+1:0] rcl_pair;
   wire logic [2*WORD_W-1:0] ror_pair;
   wire logic [WORD_W-1:0] ror_word;

   assign rol_pair = {d16, d16} << n16;
   assign rol_word = rol_pair[2*HALF_W-1:HALF_W];

   // Through-carry forms a 17-bit ring of carry and word.
   // carry joins ring
   assign rc_ext = {carry_old, d16};
   assign rcr_pair = {rc_ext, rc_ext} >> n16;
   assign rcl_pair = {rc_ext, rc_ext} << n16;

   assign ror_pair = {d32, d32} >> n32;
   assign ror_word = ror_pair[WORD_W-1:0];

   // ----------------------------------------------------------------
   // Result selection
   // ----------------------------------------------------------------
   // Idle cycles hold word and carry; only done falls back to low.
   always_comb begin
      res_next = res_reg;
      res_next.done = 1'h0;
      if (enable) begin
         res_next.done = 1'h1;
         case (req.op)
            rotate_left_16: begin
               if (!zero16) begin
                  res_next.word = {d32[WORD_W-1:HALF_W], rol_word};
                  res_next.carry_flag = rol_word[0];
               end else begin
                  res_next.word = d32;
               end
            end
            rotate_right_carry_16: begin
               res_next.word = {d32[WORD_W-1:HALF_W], rcr_pair[HALF_W-1:0]};
               res_next.carry_flag = rcr_pair[HALF_W];
            end
            rotate_left_carry_16: begin
               res_next.word = {d32[WORD_W-1:HALF_W], rcl_pair[2*HALF_W:HALF_W+1]};
               res_next.carry_flag = rcl_pair[2*HALF_W+1];
            end
            rotate_right_32: begin
               if (!zero32) begin
                  res_next.word = ror_word;
                  res_next.carry_flag = ror_word[WORD_W-1];
               end else begin
                  res_next.word = d32;
               end
            end
            default: begin
               res_next.word = d32;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Result register
   // ----------------------------------------------------------------
   // one-cycle result, carry reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         res_reg <= '{word: WORD_RESET, carry_flag: CARRY_RESET, done: 1'h0};
      end else begin
         res_reg <= res_next;
      end
   end

   assign res = res_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Delayed copy of the request, so each check gated by fire_reg compares the answer
   // with the inputs that caused it.
   logic fire_reg;
   rot_req_t req_reg;
   logic old_carry_reg;

   // The copy also keeps the carry that stood before the operation,
   // which is the bit that re-enters the word on the through-carry ops.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fire_reg <= 1'h0;
         req_reg <= '0;
         old_carry_reg <= CARRY_RESET;
      end else begin
         fire_reg <= enable;
         req_reg <= req;
         old_carry_reg <= res_reg.carry_flag;
      end
   end

   // ----------------------------------------------------------------
   // Reference values for the checks
   // ----------------------------------------------------------------
   // The references use a shift-and-or form rather than the doubled
   // copy of the datapath, so a slip in one cannot hide in the other.
   wire logic [HALF_W-1:0] low_seen;
   wire logic [N16_W-1:0] n16_seen;
   wire logic [N32_W-1:0] n32_seen;
   wire logic [4:0] back16;
   wire logic [4:0] back17;
   wire logic [5:0] back32;
   wire logic [HALF_W:0] ring_seen;
   wire logic [HALF_W-1:0] rol_expect;
   wire logic [HALF_W:0] rcr_expect;
   wire logic [HALF_W:0] rcl_expect;
   wire logic [WORD_W-1:0] ror_expect;

   assign low_seen = req_reg.operand[HALF_W-1:0];
   assign n16_seen = req_reg.count[N16_W-1:0];
   assign n32_seen = req_reg.count[N32_W-1:0];
   // Distances that bring the wrapped bits back round the ring.
   assign back16 = 5'h10 - {1'h0, n16_seen};
   assign back17 = 5'h11 - {1'h0, n16_seen};
   assign back32 = 6'h20 - {1'h0, n32_seen};
   assign ring_seen = {old_carry_reg, low_seen};
   // A zero count shifts the wrapped copy out entirely, leaving the input.
   assign rol_expect = (low_seen << n16_seen) | (low_seen >> back16);
   assign rcr_expect = (ring_seen >> n16_seen) | (ring_seen << back17);
   assign rcl_expect = (ring_seen << n16_seen) | (ring_seen >> back17);
   assign ror_expect = (req_reg.operand >> n32_seen) | (req_reg.operand << back32);

   // ----------------------------------------------------------------
   // Checks on the answer
   // ----------------------------------------------------------------
   // Every check waits out reset; the reset check looks at the first
   // edge after release, when the result register still holds zeros.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_rol_word_move: assert property (
      fire_reg && req_reg.op == rotate_left_16 && n16_seen != 4'h0
      |-> res_reg.word[HALF_W-1:0] == rol_expect)
      else $error("Left rotate 16 word wrong.");

   chk_upper_half_pass: assert property (
      fire_reg && req_reg.op != rotate_right_32
      |-> res_reg.word[WORD_W-1:HALF_W] == req_reg.operand[WORD_W-1:HALF_W])
      else $error("16-bit rotate changed the upper half.");

   chk_rol_carry_bit: assert property (
      fire_reg && req_reg.op == rotate_left_16 && n16_seen != 4'h0
      |-> res_reg.carry_flag == low_seen[back16[N16_W-1:0]])
      else $error("Left rotate 16 carry wrong.");

   chk_idle_hold_state: assert property (
      !enable
      |=> $stable(res_reg.carry_flag) && $stable(res_reg.word) && !res_reg.done)
      else $error("Idle cycle changed the result.");

   chk_rcr_carry_bit: assert property (
      fire_reg && req_reg.op == rotate_right_carry_16 && n16_seen != 4'h0
      |-> res_reg.carry_flag == low_seen[n16_seen - 4'h1])
      else $error("Right through carry flag wrong.");

   chk_rcr_fill_carry: assert property (
      fire_reg && req_reg.op == rotate_right_carry_16 && n16_seen != 4'h0
      |-> res_reg.word[back16[N16_W-1:0]] == old_carry_reg)
      else $error("Right through carry fill wrong.");

   chk_rcr_ring_word: assert property (
      fire_reg && req_reg.op == rotate_right_carry_16
      |-> {res_reg.carry_flag, res_reg.word[HALF_W-1:0]} == rcr_expect)
      else $error("Right through carry ring wrong.");

   chk_rcl_carry_bit: assert property (
      fire_reg && req_reg.op == rotate_left_carry_16 && n16_seen != 4'h0
      |-> res_reg.carry_flag == low_seen[back16[N16_W-1:0]])
      else $error("Left through carry flag wrong.");

   chk_rcl_fill_carry: assert property (
      fire_reg && req_reg.op == rotate_left_carry_16 && n16_seen != 4'h0
      |-> res_reg.word[n16_seen - 4'h1] == old_carry_reg)
      else $error("Left through carry fill wrong.");

   chk_rcl_ring_word: assert property (
      fire_reg && req_reg.op == rotate_left_carry_16
      |-> {res_reg.carry_flag, res_reg.word[HALF_W-1:0]} == rcl_expect)
      else $error("Left through carry ring wrong.");

   chk_ror_word_wrap: assert property (
      fire_reg && req_reg.op == rotate_right_32
      |-> res_reg.word == ror_expect)
      else $error("Right rotate 32 word wrong.");

   chk_ror_upper_ignored: assert property (
      enable && req.op == rotate_right_32 && req.count[4:0] == 5'h00
      |=> res_reg.word == $past(req.operand) && res_reg.carry_flag == $past(res_reg.carry_flag))
      else $error("Rotate 32 with zero effective count changed state.");

   chk_ror_one_step: assert property (
      fire_reg && req_reg.op == rotate_right_32 && n32_seen == 5'h01
      |-> res_reg.word == {req_reg.operand[0], req_reg.operand[WORD_W-1:1]})
      else $error("Rotate 32 by one step wrong.");

   chk_ror_carry_bit: assert property (
      fire_reg && req_reg.op == rotate_right_32 && n32_seen != 5'h00
      |-> res_reg.carry_flag == req_reg.operand[n32_seen - 5'h01])
      else $error("Right rotate 32 carry wrong.");

   chk_ror_carry_one: assert property (
      fire_reg && req_reg.op == rotate_right_32 && n32_seen != 5'h00 && req_reg.operand[n32_seen - 5'h01]
      |-> res_reg.carry_flag)
      else $error("Right rotate 32 carry not set.");

   chk_zero16_hold: assert property (
      enable && req.op != rotate_right_32 && req.count[3:0] == 4'h0
      |=> res_reg.word == $past(req.operand) && $stable(res_reg.carry_flag))
      else $error("Zero 16-bit count changed state.");

   chk_done_one_cycle: assert property (
      enable
      |=> res_reg.done ##1 (res_reg.done == $past(enable)))
      else $error("Done did not follow enable.");

   chk_reset_clears: assert property (
      $rose(reset_n)
      |-> res_reg.word == WORD_RESET && res_reg.carry_flag == CARRY_RESET && !res_reg.done)
      else $error("Reset did not clear the result.");

   // ----------------------------------------------------------------
   // Coverage
   // ----------------------------------------------------------------
   // Main scenarios: each 16-bit rotate with a real count, and a 32-bit rotate with a wrapped count and with a zero count.
   cov_rol16: cover property (enable && req.op == rotate_left_16 && req.count[3:0] != 4'h0);
   cov_rcr16: cover property (enable && req.op == rotate_right_carry_16 && req.count[3:0] != 4'h0);
   cov_rcl16: cover property (enable && req.op == rotate_left_carry_16 && req.count[3:0] != 4'h0);
   cov_ror32_wrap: cover property (enable && req.op == rotate_right_32 && req.count[7:5] != 3'h0);
   cov_ror32_zero: cover property (enable && req.op == rotate_right_32 && req.count[4:0] == 5'h00);

endmodule : bit_rotate_unit

//--- rot_sequencer.sv
// Purpose: Sequencer model that turns a start level into one enable pulse.
// Assumes: Start and request change a little after the rising clock edge.
// Notes: Request lines show inverted data while no rotate is asked for.
`timescale 1ns/1ps
module rot_sequencer
   import rot_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire rot_req_t req_in,
   output logic enable,
   output rot_req_t req
);
   // ----------------------------------------------------------------
   // Start edge detect
   // ----------------------------------------------------------------
   logic start_reg;
   // A held start must not repeat the rotate, so only its rising edge counts.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         start_reg <= 1'h0;
      end else begin
         start_reg <= start;
      end
   end
   assign enable = start & ~start_reg;
   // Idle request lines carry the inverse, so stale data cannot match by luck.
   assign req = enable ? req_in : rot_req_t'(~req_in);
endmodule : rot_sequencer

//--- tb.sv
// Purpose: Self-checking bench for the bit rotate unit.
// Assumes: One result per enable pulse, valid one cycle later.
// Notes: Expected words come from a bit-serial reference loop.
`timescale 1ns/1ps
module tb
   import rot_pkg::*;
;
   // ----------------------------------------------------------------
   // Harness
   // ----------------------------------------------------------------
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic start = 1'h0;
   rot_req_t req_in = '0;
   logic enable;
   rot_req_t req;
   rot_res_t res;
   logic c_exp = 1'h0;
   int failures = 0;
   int comparisons = 0;
   always #20 clk = ~clk;
   rot_sequencer rot_sequencer_inst (.clk(clk), .reset_n(reset_n), .start(start), .req_in(req_in),
      .enable(enable), .req(req));
   bit_rotate_unit bit_rotate_unit_inst (.clk(clk), .reset_n(reset_n), .enable(enable), .req(req), .res(res));
   task automatic check(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'h1) begin
         failures++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask : check
   // One bit per step is slow but plainly right, which is what a reference needs.
   function automatic logic [32:0] model(input rot_op_t op, input logic [15:0] cnt, input logic [31:0] d,
      input logic c);
      logic [16:0] ring;
      int n;
      ring = {c, d[15:0]};
      n = (op == rotate_right_32) ? int'(cnt[4:0]) : int'(cnt[3:0]);
      for (int i = 0; i < n; i++) begin
         if (op == rotate_left_16) begin
            c = d[15];
            d[15:0] = {d[14:0], d[15]};
         end else if (op == rotate_right_32) begin
            c = d[0];
            d = {d[0], d[31:1]};
         end else if (op == rotate_right_carry_16) begin
            ring = {ring[0], ring[16:1]};
         end else begin
            ring = {ring[15:0], ring[16]};
         end
      end
      if (op == rotate_right_carry_16 || op == rotate_left_carry_16) begin
         {c, d[15:0]} = ring;
      end
      return {c, d};
   endfunction : model
   task automatic go(input rot_op_t op, input logic [15:0] cnt, input logic [31:0] d);
      logic [32:0] e;
      e = model(op, cnt, d, c_exp);
      @(posedge clk);
      #1;
      check(res.done === 1'h0, "done high without request");
      start = 1'h1;
      req_in = '{op: op, count: cnt, operand: d};
      @(posedge clk);
      #1;
      start = 1'h0;
      check(res.done === 1'h1 && res.word === e[31:0] && res.carry_flag === e[32],
         $sformatf("op %0d count %0h operand %0h", op, cnt, d));
      c_exp = e[32];
   endtask : go
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_walk;
      go(rotate_left_16, 16'h0004, 32'h0000_1234);
      check(res.word === 32'h0000_2341 && res.carry_flag === 1'h1, "left 16 walk");
      go(rotate_right_32, 16'h0004, 32'h1234_ABCD);
      check(res.word === 32'hD123_4ABC && res.carry_flag === 1'h1, "right 32 walk");
   endtask : t_walk
   // Through-carry ops chain, so each one sees the carry left by the last.
   task automatic t_carry;
      for (int n = 0; n < 16; n++) begin
         go(rotate_right_carry_16, 16'(n), 32'hA5C3_5A3C ^ 32'(n * 4817));
         go(rotate_left_carry_16, 16'(n + 32), 32'h3C5A_C3A5 ^ 32'(n * 911));
      end
   endtask : t_carry
   task automatic t_counts;
      logic [15:0] cnts [8] = '{16'h0010, 16'h0011, 16'h0000, 16'h0121, 16'h0020, 16'hFF00, 16'h001F, 16'h0000};
      for (int i = 0; i < 8; i++) begin
         go((i < 3) ? rotate_left_16 : rotate_right_32, cnts[i], 32'h8001_7FFE);
      end
   endtask : t_counts
   task automatic t_idle;
      logic [32:0] e;
      e = model(rotate_right_32, 16'h0001, 32'h0000_0003, c_exp);
      // Let the low start reach the edge detector, or the held level shows no edge.
      @(posedge clk);
      #1;
      start = 1'h1;
      req_in = '{op: rotate_right_32, count: 16'h0001, operand: 32'h0000_0003};
      repeat (4) @(posedge clk);
      #1;
      start = 1'h0;
      check(res.done === 1'h0 && res.word === e[31:0] && res.carry_flag === e[32], "held start");
      c_exp = e[32];
   endtask : t_idle
   task automatic t_reset;
      go(rotate_right_32, 16'h0001, 32'h0000_0001);
      reset_n = 1'h0;
      #1;
      check(res === '0, "reset values");
      @(posedge clk);
      #1;
      reset_n = 1'h1;
      c_exp = 1'h0;
      go(rotate_right_carry_16, 16'h0001, 32'h0000_0002);
   endtask : t_reset
   task automatic wrap_up;
      if (failures == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   // The main run needs about 100 cycles; the limit leaves ample margin.
   initial begin
      #400000;
      failures++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge clk);
      #1;
      reset_n = 1'h1;
      check(res === '0, "values after reset");
      t_walk();
      t_carry();
      t_counts();
      t_idle();
      t_reset();
      wrap_up();
   end
endmodule : tb
